// *** core/fdtp_defs.svh ***
// Register indices, field positions, reset values and selector codes
`ifndef FDTP_DEFS_SVH
`define FDTP_DEFS_SVH

// Register indices; byte address is four times the index
`define FDTP_IDX_TRIG01    30'h0004_0298
`define FDTP_IDX_TRIG23    30'h0004_0299
`define FDTP_IDX_SOFT      30'h0004_029A
`define FDTP_IDX_REQ_SEL   30'h0004_02C0
`define FDTP_IDX_END_SEL   30'h0004_02D4
`define FDTP_IDX_END_DIR   30'h0004_02D6
`define FDTP_IDX_ACK_SEL   30'h0004_02DC
`define FDTP_IDX_EXT_SEL   30'h0004_02DF
`define FDTP_IDX_PEND0     30'h0004_822E
`define FDTP_IDX_PEND1     30'h0004_823E
`define FDTP_IDX_PEND2     30'h0004_824E
`define FDTP_IDX_CH3_DEST  30'h0004_825A
`define FDTP_IDX_CH3_EN    30'h0004_825C
`define FDTP_IDX_PEND3     30'h0004_825E

// Field positions
`define FDTP_END_SEL_LSB   5
`define FDTP_ACK_SEL_LSB   2
`define FDTP_EXT_SEL_LSB   4
`define FDTP_MODE_LSB      14
`define FDTP_STEP_LSB      12

// Reset values
`define FDTP_SEL_RESET     4'h0
`define FDTP_REQ_IDLE      4'hF

// Trigger source selector codes
`define FDTP_SRC_SOFT      4'h0
`define FDTP_SRC_FALL      4'h1
`define FDTP_SRC_RISE      4'h2
`define FDTP_SRC_PORT_LO   4'h3
`define FDTP_SRC_PORT_HI   4'h4
`define FDTP_SRC_T8_UF     4'h5
`define FDTP_SRC_T16A_B    4'h6
`define FDTP_SRC_T16A_A    4'h7
`define FDTP_SRC_T16B_B    4'h8
`define FDTP_SRC_T16B_A    4'h9
`define FDTP_SRC_SER_RX    4'hA
`define FDTP_SRC_SER_TX    4'hB
`define FDTP_SRC_ADC       4'hC
`define FDTP_SRC_FIFO_RX   4'hD
`define FDTP_SRC_FIFO_TX   4'hE

`define FDTP_MODE_INVALID  2'h3
`define FDTP_RESP_OKAY     2'h0
`define FDTP_RESP_SLVERR   2'h2

`endif

// *** core/fdtp_pkg.sv ***
// Types shared by the fast DMA trigger and pin control block
package fdtp_pkg;

	// One-cycle event pulses offered to one channel
	typedef struct packed {
		logic port_low;
		logic port_high;
		logic timer8_underflow;
		logic t16a_cmp_b;
		logic t16a_cmp_a;
		logic t16b_cmp_b;
		logic t16b_cmp_a;
		logic serial_rx_full;
		logic serial_tx_empty;
		logic adc_done;
		logic fifo_rx_full;
		logic fifo_tx_empty;
	} fdtp_event_type;

	// Channel 3 destination setup as seen by the transfer engine
	typedef struct packed {
		logic [1:0]  transfer_mode_field;
		logic        mode_valid;
		logic [1:0]  dest_addr_step;
		logic [11:0] dest_addr_upper;
	} fdtp_ch3_dest_type;

endpackage

// *** core/fdtp_top.sv ***
// Fast DMA trigger selection, trigger flags and pin routing
// Operation
// R1: Four-bit selector per channel, resets to software
// R2: Codes 1/2 trigger on request falling/rising edge
// R3: Codes 3-9 select port and timer events
// R4: Codes A-C select serial and converter events
// R5: Codes D/E reserved on channels 0 and 2
// R6: Writing one pulses soft trigger, reads invalid
// R7: Soft trigger only acts with software selector
// R8: Pending flag set by trigger, cleared at start
// R9: Writing one clears pending flag; read shows it
// R10: Pending flags zero after reset
// R11: Request pin select routes K5 pins
// R12: Pin selects clear on cold start only
// R13: End outputs need select and output direction
// R14: Direction readback reflects peripheral when selected
// R15: P3 select bits drive channel 0/1 acknowledge
// R16: Extension bits route channel 2/3 to P0
// R17: Channel 3 destination step only in dual mode
// R18: Channel 3 flag register clears and reports
// R19: Mode field selects action; code 11 invalid
// R20: Enable clears when transfer counter reaches zero
// R21: Request inputs synchronised before edge detection
//
// Decided for this implementation: register access over AXI4-Lite.
`include "fdtp_defs.svh"

module fdtp_top (
	// System
	input  wire logic                            clock,
	input  wire logic                            reset,
	input  wire logic                            cold_start,
	// AXI4-Lite slave
	input  wire logic [31:0]                     s_axi_awaddr,
	input  wire logic                            s_axi_awvalid,
	output wire logic                            s_axi_awready,
	input  wire logic [31:0]                     s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	input  wire logic                            s_axi_wvalid,
	output wire logic                            s_axi_wready,
	output      logic [1:0]                      s_axi_bresp,
	output      logic                            s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	input  wire logic [31:0]                     s_axi_araddr,
	input  wire logic                            s_axi_arvalid,
	output wire logic                            s_axi_arready,
	output      logic [31:0]                     s_axi_rdata,
	output      logic [1:0]                      s_axi_rresp,
	output      logic                            s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	// Trigger sources
	input  wire fdtp_pkg::fdtp_event_type [3:0]  trigger_events,
	// Transfer engine
	input  wire logic [3:0]                      transfer_start,
	input  wire logic                            ch3_count_zero,
	input  wire logic                            ch3_dual_address,
	output      logic [3:0]                      channel_trigger,
	output      logic [3:0]                      trigger_pending,
	output      logic                            ch3_enable,
	output wire fdtp_pkg::fdtp_ch3_dest_type     ch3_dest,
	// Request pins and engine strobes
	input  wire logic [3:0]                      transfer_request_n_pin,
	input  wire logic [3:0]                      transfer_end_n,
	input  wire logic [3:0]                      transfer_ack_n,
	// Shared output pins
	input  wire logic [7:0]                      gpio_out,
	input  wire logic [7:2]                      gpio_oe,
	output      logic [7:0]                      pin_out,
	output      logic [7:0]                      pin_oe
);

	logic        aw_full;
	logic        w_full;
	logic [29:0] aw_idx;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [3:0][3:0] trig_sel;
	logic [3:0]  soft_trigger;
	logic [3:0]  request_pin_select;
	logic [1:0]  end_pin_select;
	logic [1:0]  end_pin_direction;
	logic [1:0]  ack_pin_select;
	logic [3:0]  pin_extension_select;
	logic [1:0]  mode;
	logic [1:0]  step;
	logic [11:0] upper;
	logic [3:0]  req_meta;
	logic [3:0]  req_sync;
	logic [3:0]  req_prev;
	logic [3:0]  req_rise;
	logic [3:0]  req_fall;
	logic [3:0]  pend_clear;
	logic [7:0]  next_pin_out;
	logic [7:0]  next_pin_oe;
	logic [31:0] next_rdata;
	logic        rd_hit;
	logic        wr_hit;

	function automatic logic wr_at(input logic [29:0] idx);
		wr_at = do_write && aw_idx == idx && w_strb[0];
	endfunction

	// Write channel: address and data may arrive in either order
	assign s_axi_awready = !aw_full;
	assign s_axi_wready  = !w_full;
	assign do_write      = aw_full && w_full && !s_axi_bvalid;

	always_ff @(posedge clock)
		if (reset)
			aw_full <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			aw_full <= 1'b1;
		else if (do_write)
			aw_full <= 1'b0;

	always_ff @(posedge clock)
		if (s_axi_awvalid && s_axi_awready)
			aw_idx <= s_axi_awaddr[31:2];

	always_ff @(posedge clock)
		if (reset)
			w_full <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			w_full <= 1'b1;
		else if (do_write)
			w_full <= 1'b0;

	always_ff @(posedge clock)
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end

	always_comb
	begin
		case (aw_idx)
			`FDTP_IDX_TRIG01, `FDTP_IDX_TRIG23, `FDTP_IDX_SOFT,
			`FDTP_IDX_REQ_SEL, `FDTP_IDX_END_SEL, `FDTP_IDX_END_DIR,
			`FDTP_IDX_ACK_SEL, `FDTP_IDX_EXT_SEL, `FDTP_IDX_PEND0,
			`FDTP_IDX_PEND1, `FDTP_IDX_PEND2, `FDTP_IDX_CH3_DEST,
			`FDTP_IDX_CH3_EN, `FDTP_IDX_PEND3:
				wr_hit = 1'b1;
			default:
				wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock)
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `FDTP_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `FDTP_RESP_OKAY : `FDTP_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;

	// Selectors
	always_ff @(posedge clock)
		if (reset)
			trig_sel <= {4{`FDTP_SEL_RESET}}; // R1
		else
		begin
			if (wr_at(`FDTP_IDX_TRIG01))
				trig_sel[1:0] <= w_data[7:0];
			if (wr_at(`FDTP_IDX_TRIG23))
				trig_sel[3:2] <= w_data[7:0];
		end

	// Write-only pulse, never stored
	always_ff @(posedge clock)
		if (reset)
			soft_trigger <= 4'h0;
		else if (wr_at(`FDTP_IDX_SOFT))
			soft_trigger <= w_data[3:0]; // R6
		else
			soft_trigger <= 4'h0;

	// Pin routing survives a hot start
	always_ff @(posedge clock)
		if (cold_start)
		begin
			request_pin_select   <= 4'h0; // R12
			end_pin_select       <= 2'h0;
			end_pin_direction    <= 2'h0;
			ack_pin_select       <= 2'h0;
			pin_extension_select <= 4'h0;
		end
		else
		begin
			if (wr_at(`FDTP_IDX_REQ_SEL))
				request_pin_select <= {w_data[4:3], w_data[1:0]}; // R11
			if (wr_at(`FDTP_IDX_END_SEL))
				end_pin_select <= w_data[`FDTP_END_SEL_LSB +: 2];
			if (wr_at(`FDTP_IDX_END_DIR))
				end_pin_direction <= w_data[`FDTP_END_SEL_LSB +: 2];
			if (wr_at(`FDTP_IDX_ACK_SEL))
				ack_pin_select <= w_data[`FDTP_ACK_SEL_LSB +: 2];
			if (wr_at(`FDTP_IDX_EXT_SEL))
				pin_extension_select <= w_data[`FDTP_EXT_SEL_LSB +: 4];
		end

	// Channel 3 destination setup
	always_ff @(posedge clock)
		if (reset)
		begin
			mode  <= 2'h0;
			step  <= 2'h0;
			upper <= 12'h000;
		end
		else if (do_write && aw_idx == `FDTP_IDX_CH3_DEST)
		begin
			if (w_strb[1])
			begin
				mode        <= w_data[`FDTP_MODE_LSB +: 2];
				step        <= w_data[`FDTP_STEP_LSB +: 2];
				upper[11:8] <= w_data[11:8];
			end
			if (w_strb[0])
				upper[7:0] <= w_data[7:0];
		end

	assign ch3_dest.transfer_mode_field = mode;
	assign ch3_dest.mode_valid = mode != `FDTP_MODE_INVALID; // R19
	// Single-address transfers must not see a stale step
	assign ch3_dest.dest_addr_step  = ch3_dual_address ? step : 2'h0; // R17
	assign ch3_dest.dest_addr_upper = ch3_dual_address ? upper : 12'h000;

	// Software write wins over the end-of-count clear
	always_ff @(posedge clock)
		if (reset)
			ch3_enable <= 1'b0;
		else if (wr_at(`FDTP_IDX_CH3_EN))
			ch3_enable <= w_data[0];
		else if (ch3_count_zero)
			ch3_enable <= 1'b0; // R20

	// Request pins: deselected pins idle high
	always_ff @(posedge clock)
		if (reset)
		begin
			req_meta <= `FDTP_REQ_IDLE;
			req_sync <= `FDTP_REQ_IDLE;
			req_prev <= `FDTP_REQ_IDLE;
		end
		else
		begin
			req_meta <= transfer_request_n_pin | ~request_pin_select; // R11
			req_sync <= req_meta; // R21
			req_prev <= req_sync;
		end

	assign req_rise = req_sync & ~req_prev;
	assign req_fall = ~req_sync & req_prev;

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++)
		begin : g_chan
			fdtp_pkg::fdtp_event_type ev;
			assign ev = trigger_events[ch];
			always_comb
			begin
				case (trig_sel[ch])
					`FDTP_SRC_SOFT:
						channel_trigger[ch] = soft_trigger[ch]; // R7
					`FDTP_SRC_FALL:
						channel_trigger[ch] = req_fall[ch]; // R2
					`FDTP_SRC_RISE:
						channel_trigger[ch] = req_rise[ch]; // R2
					`FDTP_SRC_PORT_LO:
						channel_trigger[ch] = ev.port_low; // R3
					`FDTP_SRC_PORT_HI:
						channel_trigger[ch] = ev.port_high;
					`FDTP_SRC_T8_UF:
						channel_trigger[ch] = ev.timer8_underflow;
					`FDTP_SRC_T16A_B:
						channel_trigger[ch] = ev.t16a_cmp_b;
					`FDTP_SRC_T16A_A:
						channel_trigger[ch] = ev.t16a_cmp_a;
					`FDTP_SRC_T16B_B:
						channel_trigger[ch] = ev.t16b_cmp_b;
					`FDTP_SRC_T16B_A:
						channel_trigger[ch] = ev.t16b_cmp_a;
					`FDTP_SRC_SER_RX:
						channel_trigger[ch] = ev.serial_rx_full; // R4
					`FDTP_SRC_SER_TX:
						channel_trigger[ch] = ev.serial_tx_empty;
					`FDTP_SRC_ADC:
						channel_trigger[ch] = ev.adc_done;
					`FDTP_SRC_FIFO_RX:
						channel_trigger[ch] = (ch % 2 == 1) && ev.fifo_rx_full; // R5
					`FDTP_SRC_FIFO_TX:
						channel_trigger[ch] = (ch % 2 == 1) && ev.fifo_tx_empty;
					default:
						channel_trigger[ch] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Pending flags: a new trigger wins over any clear
	assign pend_clear = transfer_start | {wr_at(`FDTP_IDX_PEND3) & w_data[0],
		wr_at(`FDTP_IDX_PEND2) & w_data[0], wr_at(`FDTP_IDX_PEND1) & w_data[0],
		wr_at(`FDTP_IDX_PEND0) & w_data[0]}; // R9 R18

	always_ff @(posedge clock)
		if (reset)
			trigger_pending <= 4'h0; // R10
		else
			trigger_pending <= channel_trigger
				| (trigger_pending & ~pend_clear); // R8

	// Shared pins: 0,1 P1 end; 2,3 P3 ack; 4..7 P0 ack2 end2 ack3 end3
	always_comb
	begin
		next_pin_out = gpio_out;
		next_pin_oe  = {gpio_oe, end_pin_direction};
		// Per pin: select picks the strobe, direction alone gates drive
		next_pin_out[1:0] = (end_pin_select & transfer_end_n[1:0])
			| (~end_pin_select & gpio_out[1:0]); // R13
		for (int k = 0; k < 2; k++)
			if (ack_pin_select[k])
			begin
				next_pin_out[2 + k] = transfer_ack_n[k]; // R15
				next_pin_oe[2 + k]  = 1'b1;
			end
		for (int k = 0; k < 4; k++)
			if (pin_extension_select[k])
			begin
				next_pin_out[4 + k] = k[0] ? transfer_end_n[2 + k / 2]
					: transfer_ack_n[2 + k / 2]; // R16
				next_pin_oe[4 + k]  = 1'b1;
			end
	end

	always_ff @(posedge clock)
		if (reset)
		begin
			pin_out <= 8'hFF;
			pin_oe  <= 8'h00;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe  <= next_pin_oe;
		end

	// Read channel
	assign s_axi_arready = !s_axi_rvalid;

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr[31:2])
			`FDTP_IDX_TRIG01:   next_rdata[7:0] = trig_sel[1:0];
			`FDTP_IDX_TRIG23:   next_rdata[7:0] = trig_sel[3:2];
			`FDTP_IDX_SOFT:     next_rdata = 32'h0000_0000; // R6
			`FDTP_IDX_REQ_SEL:
				next_rdata[4:0] = {request_pin_select[3:2], 1'b0,
					request_pin_select[1:0]};
			`FDTP_IDX_END_SEL:
				next_rdata[`FDTP_END_SEL_LSB +: 2] = end_pin_select;
			`FDTP_IDX_END_DIR:
				next_rdata[`FDTP_END_SEL_LSB +: 2] = (end_pin_select & pin_oe[1:0])
					| (~end_pin_select & end_pin_direction); // R14
			`FDTP_IDX_ACK_SEL:
				next_rdata[`FDTP_ACK_SEL_LSB +: 2] = ack_pin_select;
			`FDTP_IDX_EXT_SEL:
				next_rdata[`FDTP_EXT_SEL_LSB +: 4] = pin_extension_select;
			`FDTP_IDX_PEND0:    next_rdata[0] = trigger_pending[0];
			`FDTP_IDX_PEND1:    next_rdata[0] = trigger_pending[1];
			`FDTP_IDX_PEND2:    next_rdata[0] = trigger_pending[2];
			`FDTP_IDX_PEND3:    next_rdata[0] = trigger_pending[3]; // R18
			`FDTP_IDX_CH3_DEST: next_rdata[15:0] = {mode, step, upper};
			`FDTP_IDX_CH3_EN:   next_rdata[0] = ch3_enable;
			default:            rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock)
		if (reset)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `FDTP_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= rd_hit ? `FDTP_RESP_OKAY : `FDTP_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;

	// Checks
	sequence pin_goes_high;
		request_pin_select[1] && !transfer_request_n_pin[1]
		##1 request_pin_select[1] && transfer_request_n_pin[1];
	endsequence

	sequence rise_held;
		(trig_sel[1] == `FDTP_SRC_RISE && request_pin_select[1]
			&& transfer_request_n_pin[1])[*2];
	endsequence

	sel_after_reset_a: assert property (@(posedge clock) // R1
		reset |=> trig_sel == 16'h0000)
		else $error("selectors not cleared by reset");
	rise_edge_a: assert property (@(posedge clock) disable iff (reset) // R2
		pin_goes_high ##1 rise_held |-> channel_trigger[1])
		else $error("rising request edge missed");
	soft_gate_a: assert property (@(posedge clock) disable iff (reset) // R7
		trig_sel[1] == `FDTP_SRC_SOFT |-> channel_trigger[1] == soft_trigger[1])
		else $error("software trigger gating wrong");
	soft_ignore_a: assert property (@(posedge clock) disable iff (reset) // R7
		trig_sel[1] != `FDTP_SRC_SOFT && soft_trigger[1] && !req_rise[1]
		&& !req_fall[1] && trigger_events[1] == '0 |-> !channel_trigger[1])
		else $error("software trigger not ignored");
	pend_set_a: assert property (@(posedge clock) disable iff (reset) // R8
		channel_trigger[2] |=> trigger_pending[2])
		else $error("pending flag not set by trigger");
	pend_clear_a: assert property (@(posedge clock) disable iff (reset) // R9
		wr_at(`FDTP_IDX_PEND0) && w_data[0] && !channel_trigger[0]
		|=> !trigger_pending[0])
		else $error("pending flag not cleared by write");
	end_input_a: assert property (@(posedge clock) disable iff (reset) // R13
		end_pin_select[1] && !end_pin_direction[1] |=> !pin_oe[1])
		else $error("end pin driven while direction is input");
	ack_drive_a: assert property (@(posedge clock) disable iff (reset) // R15
		ack_pin_select[1] |=> pin_oe[3] && pin_out[3] == $past(transfer_ack_n[1]))
		else $error("acknowledge pin not driven");
	ext_drive_a: assert property (@(posedge clock) disable iff (reset) // R16
		pin_extension_select[3] |=> pin_oe[7]
		&& pin_out[7] == $past(transfer_end_n[3]))
		else $error("extension end pin not driven");
	enable_clear_a: assert property (@(posedge clock) disable iff (reset) // R20
		ch3_count_zero && !wr_at(`FDTP_IDX_CH3_EN) |=> !ch3_enable)
		else $error("enable not cleared at count zero");

endmodule

// *** tb/fdtp_io_device.sv ***
// Behavioural external device that drives the transfer request pins
module fdtp_io_device (
	// System
	input  wire logic       clock,
	input  wire logic       reset,
	// Bench command: hold a request per channel while high
	input  wire logic [3:0] want,
	// Request pins, active low
	output      logic [3:0] request_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins are always driven, so idle is a solid high, never a stale level
	always_ff @(posedge clock)
	begin
		if (reset)
			request_n <= 4'hF;
		else
			request_n <= ~want;
	end
endmodule

// *** tb/tb_fast_dma_trigger_and_pin_control.sv ***
// Register-level tests of the fast DMA trigger and pin control block
`include "fdtp_defs.svh"

module tb_fast_dma_trigger_and_pin_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 0, reset, cold_start;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	fdtp_pkg::fdtp_event_type [3:0] trigger_events;
	fdtp_pkg::fdtp_ch3_dest_type ch3_dest;
	logic [3:0] transfer_start, channel_trigger, trigger_pending, want;
	logic [3:0] transfer_request_n_pin, transfer_end_n, transfer_ack_n;
	logic ch3_count_zero, ch3_dual_address, ch3_enable;
	logic [7:0] gpio_out, pin_out, pin_oe;
	logic [7:2] gpio_oe;
	logic [31:0] data;
	logic [11:0] ev;
	int fail_count = 0, checked = 0, cnt0 = 0, cnt1 = 0, n0, n1;

	always #12.5 clock = ~clock;

	fdtp_top dut_u (.clock, .reset, .cold_start, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.trigger_events, .transfer_start, .ch3_count_zero,
		.ch3_dual_address, .channel_trigger, .trigger_pending, .ch3_enable,
		.ch3_dest, .transfer_request_n_pin, .transfer_end_n,
		.transfer_ack_n, .gpio_out, .gpio_oe, .pin_out, .pin_oe);

	fdtp_io_device dev_u (.clock, .reset, .want,
		.request_n(transfer_request_n_pin));

	// Pre-edge values: exactly one pulse per qualifying pin edge
	always @(posedge clock)
	begin
		if (channel_trigger[0] === 1'b1)
			cnt0++;
		if (channel_trigger[1] === 1'b1)
			cnt1++;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic end_test(input string s);
		$display("test %s done at %0t", s, $time);
	endtask

	// Handshakes sampled just before the edge they complete on
	task automatic wr(input logic [29:0] idx, input logic [31:0] d);
		logic a, w;
		@(posedge clock);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		a = 1;
		w = 1;
		while (a | w)
		begin
			@(negedge clock);
			a = a & ~s_axi_awready;
			w = w & ~s_axi_wready;
			@(posedge clock);
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		do
			@(negedge clock);
		while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		@(posedge clock);
		s_axi_bready <= 0;
	endtask

	task automatic rd(input logic [29:0] idx);
		logic a;
		@(posedge clock);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		a = 1;
		while (a)
		begin
			@(negedge clock);
			a = ~s_axi_arready;
			@(posedge clock);
			s_axi_arvalid <= a;
		end
		do
			@(negedge clock);
		while (s_axi_rvalid !== 1'b1);
		data = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge clock);
		s_axi_rready <= 0;
	endtask

	// Reserved bits read undefined, so only the field bits are compared
	task automatic rc(input logic [29:0] idx, input logic [31:0] exp,
		input logic [31:0] mask);
		rd(idx);
		check(data & mask, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic start(input logic [3:0] m);
		@(posedge clock);
		transfer_start <= m;
		@(posedge clock);
		transfer_start <= 0;
	endtask

	task automatic pulse_ev(input logic [11:0] e);
		@(posedge clock);
		trigger_events <= {4{e}};
		@(posedge clock);
		trigger_events <= '0;
	endtask

	task automatic do_reset(input logic cold);
		@(posedge clock);
		reset <= 1;
		cold_start <= cold;
		repeat (12) @(posedge clock);
		reset <= 0;
		cold_start <= 0;
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		fail_count++;
		$display("wrong value at %0t: run timed out", $time);
		stop_test();
	end

	initial
	begin
		reset = 1;
		cold_start = 1;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		trigger_events = '0;
		transfer_start = 0;
		want = 0;
		{ch3_count_zero, ch3_dual_address} = '0;
		transfer_end_n = 4'hA;
		transfer_ack_n = 4'h5;
		gpio_out = 8'hC3;
		gpio_oe = 6'h2C;
		repeat (12) @(posedge clock);
		reset <= 0;
		cold_start <= 0;
		rc(`FDTP_IDX_TRIG01, 0, 32'hFF);
		rc(`FDTP_IDX_TRIG23, 0, 32'hFF);
		rc(`FDTP_IDX_PEND0, 0, 1);
		rc(`FDTP_IDX_PEND3, 0, 1);
		wr(`FDTP_IDX_SOFT, 0);
		settle(2);
		check(trigger_pending, 0);
		end_test("reset values");

		wr(`FDTP_IDX_SOFT, 32'hF);
		settle(2);
		check(trigger_pending, 4'hF);
		rc(`FDTP_IDX_PEND3, 1, 1);
		wr(`FDTP_IDX_PEND0, 0);
		rc(`FDTP_IDX_PEND0, 1, 1);
		wr(`FDTP_IDX_PEND0, 1);
		rc(`FDTP_IDX_PEND0, 0, 1);
		start(4'hE);
		settle(1);
		check(trigger_pending, 0);
		end_test("software trigger");

		wr(`FDTP_IDX_TRIG01, 32'h21);
		wr(`FDTP_IDX_SOFT, 32'hF);
		settle(2);
		check(trigger_pending, 4'hC);
		start(4'hC);
		// Pins not routed yet: request edges must be ignored
		@(posedge clock);
		want <= 4'h3;
		settle(6);
		want <= 0;
		settle(6);
		check(trigger_pending, 0);
		wr(`FDTP_IDX_REQ_SEL, 32'h1B);
		rc(`FDTP_IDX_REQ_SEL, 32'h1B, 32'h1B);
		settle(4);
		n0 = cnt0;
		n1 = cnt1;
		want <= 4'h3;
		settle(6);
		check(trigger_pending, 4'h1);
		want <= 0;
		settle(6);
		check(trigger_pending, 4'h3);
		check(cnt0 - n0, 1);
		check(cnt1 - n1, 1);
		start(4'h3);
		settle(1);
		check(trigger_pending, 0);
		end_test("request pins");

		for (int c = 3; c < 15; c++)
		begin
			wr(`FDTP_IDX_TRIG01, 32'(c * 17));
			wr(`FDTP_IDX_TRIG23, 32'(c * 17));
			ev = 12'h1 << (14 - c);
			pulse_ev(~ev);
			settle(1);
			check(trigger_pending, 0);
			pulse_ev(ev);
			settle(1);
			check(trigger_pending, c > 12 ? 4'hA : 4'hF);
			start(4'hF);
		end
		end_test("event sources");

		settle(1);
		check({pin_out[7:2], pin_oe}, {6'h30, 8'hB0});
		wr(`FDTP_IDX_END_SEL, 32'h60);
		wr(`FDTP_IDX_END_DIR, 32'h60);
		wr(`FDTP_IDX_ACK_SEL, 32'hC);
		wr(`FDTP_IDX_EXT_SEL, 32'hF0);
		settle(2);
		check({pin_out, pin_oe}, 16'h96FF);
		wr(`FDTP_IDX_END_DIR, 32'h20);
		settle(2);
		check(pin_oe, 8'hFD);
		check(pin_out[1:0], 2'b10);
		rc(`FDTP_IDX_END_DIR, 32'h20, 32'h60);
		wr(`FDTP_IDX_EXT_SEL, 0);
		wr(`FDTP_IDX_ACK_SEL, 0);
		settle(2);
		check({pin_out[7:4], pin_oe[7:4]}, 8'hCB);
		check({pin_out[3:2], pin_oe[3:2]}, 0);
		end_test("pin routing");

		do_reset(0);
		rc(`FDTP_IDX_END_SEL, 32'h60, 32'h60);
		rc(`FDTP_IDX_REQ_SEL, 32'h1B, 32'h1B);
		rc(`FDTP_IDX_TRIG01, 0, 32'hFF);
		do_reset(1);
		rc(`FDTP_IDX_END_SEL, 0, 32'h60);
		rc(`FDTP_IDX_REQ_SEL, 0, 32'h1B);
		end_test("hot and cold start");

		wr(`FDTP_IDX_CH3_DEST, 32'hE5A5);
		rc(`FDTP_IDX_CH3_DEST, 32'hE5A5, 32'hFFFF);
		settle(1);
		check(ch3_dest, 17'h1_8000);
		@(posedge clock);
		ch3_dual_address <= 1;
		settle(1);
		check(ch3_dest, {2'b11, 1'b0, 2'b10, 12'h5A5});
		wr(`FDTP_IDX_CH3_DEST, 32'h4000);
		settle(1);
		check(ch3_dest.mode_valid, 1);
		wr(`FDTP_IDX_CH3_EN, 1);
		settle(1);
		check(ch3_enable, 1);
		@(posedge clock);
		ch3_count_zero <= 1;
		@(posedge clock);
		ch3_count_zero <= 0;
		settle(1);
		check(ch3_enable, 0);
		rc(`FDTP_IDX_CH3_EN, 0, 1);
		end_test("channel 3 setup");

		rd(30'h1);
		check(resp, `FDTP_RESP_SLVERR);
		wr(30'h1, 0);
		check(resp, `FDTP_RESP_SLVERR);
		rd(`FDTP_IDX_TRIG01);
		check(resp, `FDTP_RESP_OKAY);
		end_test("unmapped access");
		stop_test();
	end
endmodule
